// ===== verilog/can_xfer_pkg.sv
package can_xfer_pkg;
   // Register byte offsets of interface set 1; set n adds (n-1) * set stride
   localparam logic [7:0] set_stride = 8'h60;
   localparam logic [7:0] command_request_off = 8'h20;
   localparam logic [7:0] transfer_select_off = 8'h24;
   localparam logic [7:0] buffer_base_off = 8'h28;
   localparam int buffer_count = 9;
   // Buffer register indices
   localparam int buf_mask1 = 0;
   localparam int buf_mask2 = 1;
   localparam int buf_arb1 = 2;
   localparam int buf_arb2 = 3;
   localparam int buf_mcon = 4;
   localparam int buf_data_a1 = 5;
   localparam int buf_data_a2 = 6;
   localparam int buf_data_b1 = 7;
   localparam int buf_data_b2 = 8;
   // Reset values
   localparam logic [31:0] transfer_select_rst = 32'h0000_0000;
   localparam logic [5:0] message_number_rst = 6'h01;
   localparam logic [15:0] mask_rst = 16'hFFFF;
   localparam logic [15:0] buf_rst = 16'h0000;
   // Transfer select fields
   localparam int dir_bit = 7;
   localparam int mask_sel_bit = 6;
   localparam int arb_sel_bit = 5;
   localparam int ctrl_sel_bit = 4;
   localparam int clear_pending_bit = 3;
   localparam int txreq_newdata_bit = 2;
   localparam int low_data_bit = 1;
   localparam int high_data_bit = 0;
   localparam int select_width = 8;
   // Command request fields
   localparam int busy_bit = 15;
   localparam int msgnum_width = 6;
   // Message control fields
   localparam int new_data_pos = 15;
   localparam int int_pending_pos = 13;
   localparam int tx_request_pos = 8;
   // Message object word layout
   localparam int obj_count = 32;
   localparam int obj_addr_width = 5;
   localparam int obj_width = 144;
   localparam int grp_count = 5;
   localparam int grp_mask = 0;
   localparam int grp_arb = 1;
   localparam int grp_ctrl = 2;
   localparam int grp_data_a = 3;
   localparam int grp_data_b = 4;
   localparam int grp_lsb [grp_count] = '{0, 32, 64, 80, 112};
   localparam int grp_len [grp_count] = '{32, 32, 16, 32, 32};
   // Transfer timing, peripheral clock periods
   localparam int xfer_min_cycles = 3;
   localparam int xfer_max_cycles = 6;
   typedef enum logic [1:0]
   {
      xf_idle = 2'b00,
      xf_read = 2'b01,
      xf_merge = 2'b11,
      xf_done = 2'b10
   } xfer_state_e;
endpackage

// ===== verilog/msg_obj_ram.sv
`timescale 1ns/1ps
module msg_obj_ram
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [can_xfer_pkg::obj_addr_width-1:0] addr,
   input wire logic [can_xfer_pkg::grp_count-1:0] grp_we,
   input wire logic [can_xfer_pkg::obj_width-1:0] wdata,
   output logic [can_xfer_pkg::obj_width-1:0] rdata
);
   logic [can_xfer_pkg::obj_width-1:0] mem [can_xfer_pkg::obj_count];
   logic [can_xfer_pkg::obj_width-1:0] bit_we;

   // Per-group write enables so unselected fields keep their contents
   genvar g;
   generate
      for (g = 0; g < can_xfer_pkg::grp_count; g++)
      begin : g_we
         assign bit_we[can_xfer_pkg::grp_lsb[g] +: can_xfer_pkg::grp_len[g]] =
            {can_xfer_pkg::grp_len[g]{grp_we[g]}};
      end
   endgenerate

   always_ff @(posedge hclk)
   begin
      if (wr_en)
      begin
         mem[addr] <= (mem[addr] & ~bit_we) | (wdata & bit_we);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rdata <= '0;
      end
      else if (rd_en)
      begin
         rdata <= mem[addr];
      end
   end
endmodule // msg_obj_ram

// ===== verilog/can_message_if_transfer_select.sv
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
// How it works
// - Bit 7 low copies object into buffers; high copies buffers into object.
// - Bit 6 moves identifier mask with mask direction and extended bits.
// - Bit 5 moves identifier, direction, extended and object-valid bits.
// - Bit 4 moves message control bits; otherwise destination control unchanged.
// - Clear-pending select bit is ignored on write transfers.
// - Read with bit 3 set clears object's interrupt pending flag (bit 13).
// - Write with bit 2 clear leaves object's transmit request flag unchanged.
// - Own select register per set, 0x60 stride, resets zero; bits 7..0 read/write, bits 31..8 read as zero.
// - Write with bit 2 set sets transmit request, ignoring buffer's request bit.
// - Read with bit 2 set clears new data; buffer gets pre-clear value.
// - Bit 1 moves data bytes 3..0; bit 0 moves data bytes 7..4.
// - Writing message number while idle starts transfer, sets busy, done in 3..6 clocks.
module can_message_if_transfer_select
#(
   parameter logic [7:0] if_set_index = 8'h00
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic busy
);
   localparam logic [7:0] set_off = 8'(if_set_index * can_xfer_pkg::set_stride);
   localparam int nbuf = can_xfer_pkg::buffer_count;

   // Buffer index of a local offset, or nbuf when the offset is not a buffer
   function automatic logic [3:0] buf_index(input logic [7:0] off);
      logic [7:0] rel;
      rel = off - can_xfer_pkg::buffer_base_off;
      if (off >= can_xfer_pkg::buffer_base_off && rel[1:0] == 2'b00 && rel[7:2] < 6'(nbuf))
         buf_index = rel[5:2];
      else
         buf_index = 4'(nbuf);
   endfunction

   // Number 0 wraps to the last object, numbers above 32 wrap into 1..31
   function automatic logic [4:0] obj_index(input logic [5:0] num);
      obj_index = 5'(num[4:0] - 5'h01);
   endfunction

   logic [7:0] dph_off_r;
   logic dph_wr_r;
   logic dph_rd_r;
   logic [7:0] select_r;
   logic [5:0] msgnum_r;
   logic [15:0] buf_r [nbuf];
   logic [15:0] buf_nxt [nbuf];
   logic [15:0] load_val [nbuf];
   logic [nbuf-1:0] load_en;
   logic [31:0] rd_word;
   can_xfer_pkg::xfer_state_e state_r;
   can_xfer_pkg::xfer_state_e state_nxt;
   logic [can_xfer_pkg::obj_width-1:0] obj_rdata;
   logic [can_xfer_pkg::obj_width-1:0] obj_wdata;
   logic [can_xfer_pkg::grp_count-1:0] obj_grp_we;
   logic [15:0] old_ctrl;
   logic [15:0] new_ctrl;

   wire access = hsel && hready && htrans[1];
   wire [7:0] aph_off = haddr[7:0] - set_off;
   wire [3:0] wr_idx = buf_index(dph_off_r);
   wire [3:0] rd_idx = buf_index(dph_off_r);
   wire sw_creq = dph_wr_r && dph_off_r == can_xfer_pkg::command_request_off;
   wire sw_select = dph_wr_r && dph_off_r == can_xfer_pkg::transfer_select_off;
   wire start = sw_creq && state_r == can_xfer_pkg::xf_idle;
   wire is_write = select_r[can_xfer_pkg::dir_bit];
   wire sel_mask = select_r[can_xfer_pkg::mask_sel_bit];
   wire sel_arb = select_r[can_xfer_pkg::arb_sel_bit];
   wire sel_ctrl = select_r[can_xfer_pkg::ctrl_sel_bit];
   wire sel_clrpnd = select_r[can_xfer_pkg::clear_pending_bit];
   wire sel_txnd = select_r[can_xfer_pkg::txreq_newdata_bit];
   wire sel_low = select_r[can_xfer_pkg::low_data_bit];
   wire sel_high = select_r[can_xfer_pkg::high_data_bit];
   wire merge = state_r == can_xfer_pkg::xf_merge;
   wire ram_rd = state_r == can_xfer_pkg::xf_read;

   // Next state: idle, read object, merge and write back, release busy
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         can_xfer_pkg::xf_idle:
            if (start)
               state_nxt = can_xfer_pkg::xf_read;
         can_xfer_pkg::xf_read:
            state_nxt = can_xfer_pkg::xf_merge;
         can_xfer_pkg::xf_merge:
            state_nxt = can_xfer_pkg::xf_done;
         can_xfer_pkg::xf_done:
            state_nxt = can_xfer_pkg::xf_idle;
         default:
            state_nxt = can_xfer_pkg::xf_idle;
      endcase
   end

   // Control merge; always read-modify-write so flag updates touch single bits
   assign old_ctrl = obj_rdata[can_xfer_pkg::grp_lsb[can_xfer_pkg::grp_ctrl] +: 16];
   always_comb
   begin
      new_ctrl = old_ctrl;
      if (is_write)
      begin
         if (sel_ctrl)
            new_ctrl = buf_r[can_xfer_pkg::buf_mcon];
         // Request bit comes only from the select bit, never from the buffer
         new_ctrl[can_xfer_pkg::tx_request_pos] = sel_txnd ? 1'b1 :
            old_ctrl[can_xfer_pkg::tx_request_pos];
         // Clear-pending select has no effect here
      end
      else
      begin
         if (sel_clrpnd)
            new_ctrl[can_xfer_pkg::int_pending_pos] = 1'b0;
         if (sel_txnd)
            new_ctrl[can_xfer_pkg::new_data_pos] = 1'b0;
      end
   end

   assign obj_wdata = {buf_r[can_xfer_pkg::buf_data_b2], buf_r[can_xfer_pkg::buf_data_b1],
                       buf_r[can_xfer_pkg::buf_data_a2], buf_r[can_xfer_pkg::buf_data_a1],
                       new_ctrl,
                       buf_r[can_xfer_pkg::buf_arb2], buf_r[can_xfer_pkg::buf_arb1],
                       buf_r[can_xfer_pkg::buf_mask2], buf_r[can_xfer_pkg::buf_mask1]};
   assign obj_grp_we = {is_write && sel_high, is_write && sel_low, 1'b1,
                        is_write && sel_arb, is_write && sel_mask};

   // Buffer loads on read transfers; control shows the value before clearing
   genvar i;
   generate
      for (i = 0; i < nbuf; i++)
      begin : g_buf
         assign load_val[i] = obj_rdata[16*i +: 16];
         assign buf_nxt[i] = load_en[i] ? load_val[i] :
                             (dph_wr_r && wr_idx == 4'(i)) ? hwdata[15:0] : buf_r[i];
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               buf_r[i] <= (i < 2) ? can_xfer_pkg::mask_rst : can_xfer_pkg::buf_rst;
            else
               buf_r[i] <= buf_nxt[i];
         end
      end
   endgenerate
   wire rd_load = merge && !is_write;
   assign load_en = {{2{rd_load && sel_high}}, {2{rd_load && sel_low}},
                     rd_load && sel_ctrl,
                     {2{rd_load && sel_arb}},
                     {2{rd_load && sel_mask}}};

   msg_obj_ram u_ram
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .rd_en(ram_rd),
      .wr_en(merge),
      .addr(obj_index(msgnum_r)),
      .grp_we(obj_grp_we),
      .wdata(obj_wdata),
      .rdata(obj_rdata)
   );

   // Read mux; the select register shows only its low byte
   assign rd_word = (dph_off_r == can_xfer_pkg::transfer_select_off) ?
                       {24'h00_0000, select_r} :
                    (dph_off_r == can_xfer_pkg::command_request_off) ?
                       {16'h0000, busy, 9'h000, msgnum_r} :
                    (rd_idx < 4'(nbuf)) ? {16'h0000, buf_r[rd_idx]} : 32'h0000_0000;

   // Reads take one wait state so a write just before is always visible
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_off_r <= 8'h00;
         dph_wr_r <= 1'b0;
         dph_rd_r <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end
      else
      begin
         dph_wr_r <= access && hwrite;
         dph_rd_r <= access && !hwrite;
         if (access)
            dph_off_r <= aph_off;
         hreadyout <= !(access && !hwrite);
         if (dph_rd_r)
            hrdata <= rd_word;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         select_r <= can_xfer_pkg::transfer_select_rst[7:0];
         msgnum_r <= can_xfer_pkg::message_number_rst;
         busy <= 1'b0;
         state_r <= can_xfer_pkg::xf_idle;
      end
      else
      begin
         state_r <= state_nxt;
         if (sw_select)
            select_r <= hwdata[can_xfer_pkg::select_width-1:0];
         if (start)
            msgnum_r <= hwdata[can_xfer_pkg::msgnum_width-1:0];
         if (start)
            busy <= 1'b1;
         else if (state_r == can_xfer_pkg::xf_done)
            busy <= 1'b0;
      end
   end
endmodule // can_message_if_transfer_select

// ===== bench/xfer_select_monitor.sv
`timescale 1ns/1ps
module xfer_select_monitor
#(
   parameter logic [7:0] if_set_index = 8'h00
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic busy
);
   localparam logic [7:0] base = 8'(if_set_index * 8'h60);
   wire logic taken = hsel && hready && htrans[1];
   wire logic cmd_wr = taken && hwrite && haddr[7:0] == base + 8'h20;
   logic rd_ph_r;
   logic cmd_q_r;
   logic [7:0] rd_addr_r;
   wire logic done = rd_ph_r && hreadyout;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_ph_r <= 1'b0;
         cmd_q_r <= 1'b0;
         rd_addr_r <= 8'h00;
      end
      else
      begin
         cmd_q_r <= cmd_wr;
         if (taken)
         begin
            rd_ph_r <= !hwrite;
            rd_addr_r <= haddr[7:0];
         end
         else if (hreadyout)
            rd_ph_r <= 1'b0;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_wait_s;
      !hreadyout ##1 hreadyout;
   endsequence
   // Busy stands three to six periods: high at three edges, low by the seventh
   sequence busy_hold_s;
      busy [*3] ##[1:4] !busy;
   endsequence
   read_wait_a: assert property (taken && !hwrite |=> rd_wait_s)
      else $error("read wait state wrong");
   write_nowait_a: assert property (taken && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
   busy_start_a: assert property (cmd_wr && !busy |=> ##1 busy)
      else $error("busy not set by command");
   busy_span_a: assert property ($rose(busy) |-> busy_hold_s)
      else $error("busy length wrong");
   busy_cause_a: assert property ($rose(busy) |-> $past(cmd_q_r))
      else $error("busy without command");
   sel_reserved_a: assert property (
      done && rd_addr_r == base + 8'h24 |-> hrdata[31:8] == 24'h0)
      else $error("select upper bits not zero");
   other_set_a: assert property (
      done && rd_addr_r == base - 8'h3C |-> hrdata == 32'h0)
      else $error("foreign set address answered");
endmodule // xfer_select_monitor

// ===== bench/ahb_host_model.sv
`timescale 1ns/1ps
module ahb_host_model
(
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial
   begin
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // Each phase is held until hready is seen high at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
endmodule // ahb_host_model

// ===== bench/tb_can_message_if_transfer_select.sv
`timescale 1ns/1ps
module tb_can_message_if_transfer_select;
   typedef struct packed {logic [7:0] sel; logic [15:0] f; logic [15:0] mc; logic [5:0] n;} row_s;
   localparam logic [7:0] base = 8'h60;
   localparam int grp_of [9] = '{4, 4, 3, 3, 2, 1, 1, 0, 0};
   // Fill 0 means the object pattern A000 plus buffer index
   localparam row_s rows [9] = '{
      '{8'hF7, 16'h0, 16'h0, 6'h03},
      '{8'h40, 16'h5555, 16'h0, 6'h03},
      '{8'h20, 16'h5555, 16'h0, 6'h03},
      '{8'h02, 16'h5555, 16'h0, 6'h03},
      '{8'h01, 16'h5555, 16'h0, 6'h03},
      '{8'h1C, 16'h5555, 16'hA104, 6'h03},
      '{8'h10, 16'h5555, 16'h0104, 6'h23},
      '{8'h98, 16'h2000, 16'h0, 6'h03},
      '{8'h73, 16'h5555, 16'h2100, 6'h03}};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   wire logic hsel;
   wire logic [31:0] haddr;
   wire logic [1:0] htrans;
   wire logic hwrite;
   wire logic [2:0] hsize;
   wire logic [31:0] hwdata;
   wire logic [31:0] hrdata;
   wire logic hreadyout;
   wire logic hresp;
   wire logic busy;
   int error_cnt = 0;
   int check_count = 0;
   always #5 hclk = ~hclk;
   ahb_host_model ahb_host_model_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));
   can_message_if_transfer_select #(.if_set_index(8'h01)) can_message_if_transfer_select_inst
      (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .busy(busy));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("FAIL %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb_host_model_inst.xfer(1'b1, base + a, d, q);
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb_host_model_inst.xfer(1'b0, base + a, 32'h0, q);
      cmp(q, e);
   endtask
   // Edges waited for busy low; lo guards the three-period minimum after a start
   task automatic idle(input int lo);
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 10)
      begin
         @(posedge hclk);
         k++;
      end
      cmp({31'h0, k >= lo && k < 7}, 32'h1);
   endtask
   task automatic run(input logic [5:0] n);
      wr(8'h20, {26'h0, n});
      @(posedge hclk);
      cmp({31'h0, busy}, 32'h1);
      idle(3);
   endtask
   function automatic logic [15:0] exp_buf(input row_s w, input int i);
      logic [4:0] g;
      logic [15:0] f;
      g = {w.sel[6], w.sel[5], w.sel[4], w.sel[1], w.sel[0]} & {5{~w.sel[7]}};
      f = (w.f == 16'h0) ? 16'hA000 + 16'(i) : w.f;
      if (!g[grp_of[i]])
         return f;
      return (i == 4) ? w.mc : 16'hA000 + 16'(i);
   endfunction
   initial
   begin
      #100000;
      error_cnt++;
      tally_and_finish();
   end
   initial
   begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      chk(8'h24, 32'h0);
      wr(8'h24, 32'hFFFF_FFFF);
      wr(8'hC4, 32'h0);
      chk(8'h24, 32'h0000_00FF);
      chk(8'hC4, 32'h0);
      for (int r = 0; r < 9; r++)
      begin
         for (int i = 0; i < can_xfer_pkg::buffer_count; i++)
            wr(8'h28 + 8'(4 * i), {16'h0, (rows[r].f == 16'h0) ? 16'hA000 + 16'(i) : rows[r].f});
         wr(8'h24, {24'h0, rows[r].sel});
         run(rows[r].n);
         for (int i = 0; i < can_xfer_pkg::buffer_count; i++)
            chk(8'h28 + 8'(4 * i), {16'h0, exp_buf(rows[r], i)});
      end
      // A command that lands while busy must not replace the message number
      wr(8'h24, 32'h0000_00C0);
      wr(8'h20, 32'h0000_0005);
      wr(8'h20, 32'h0000_0007);
      idle(0);
      chk(8'h20, 32'h0000_0005);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      chk(8'h24, 32'h0);
      chk(8'h28, 32'h0000_FFFF);
      tally_and_finish();
   end
endmodule // tb_can_message_if_transfer_select
bind can_message_if_transfer_select xfer_select_monitor #(.if_set_index(if_set_index)) mon_inst
   (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .busy(busy));
